// >>> hw/dect_counter_timer.sv
// Dual event counter and timer with classic Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module dect_counter_timer
    import dect_pkg::*;
#(
    parameter int CW = CNT_W
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    // Camera event sources
    input  wire dect_pkg::dect_src_s   src_i,
    // Events and interrupt
    output logic [NUM_CNT-1:0]         delay_done_event,
    output logic [NUM_CNT-1:0]         duration_done_event,
    output logic                       microsecond_pulse,
    output logic                       irq
);
    import dect_pkg::*;

    logic                  counter_index_select;
    logic [SRC_W-1:0]      increment_source_select [NUM_CNT];
    logic [MODE_W-1:0]     increment_qualify_mode  [NUM_CNT];
    logic [SRC_W-1:0]      start_source_select     [NUM_CNT];
    logic [MODE_W-1:0]     start_qualify_mode      [NUM_CNT];
    logic [SRC_W-1:0]      clear_source_select     [NUM_CNT];
    logic [MODE_W-1:0]     clear_qualify_mode      [NUM_CNT];
    logic [CW-1:0]         start_delay_count       [NUM_CNT];
    logic [CW-1:0]         end_duration_count      [NUM_CNT];
    logic [CW-1:0]         live_count              [NUM_CNT];
    logic [CW-1:0]         count_captured_on_clear [NUM_CNT];
    dect_state_e           counter_state           [NUM_CNT];
    logic [NUM_CNT-1:0]    inc_hit;
    logic [NUM_CNT-1:0]    start_hit;
    logic [NUM_CNT-1:0]    clear_hit;
    logic [IRQ_W-1:0]      irq_status;
    logic [IRQ_W-1:0]      irq_enable;
    logic [IRQ_W-1:0]      irq_event;
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
    logic [NUM_SRC-1:0]    src_vec;
    logic                  wb_req;
    logic                  wb_wr;
    logic [31:0]           next_rd;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Request taken in its first cycle; ack always follows one edge later
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_req && wb_we_i;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? next_rd : 32'h0000_0000;
        end
    end

    // Tick: one cycle high every microsecond
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt          <= '0;
            microsecond_pulse <= 1'b0;
        end else begin
            microsecond_pulse <= tick_cnt == '0;
            tick_cnt <= (tick_cnt == $bits(tick_cnt)'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    // Source list; counter events enter registered to avoid combinational loops
    assign src_vec = {src_i.frame_trig_wait, src_i.exp_end, src_i.exp_start, src_i.logic_blk,
                      duration_done_event, delay_done_event, src_i.user_out, src_i.line,
                      microsecond_pulse, 1'b0};

    // Configuration written by software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_index_select <= 1'b0;
            for (int i = 0; i < NUM_CNT; i++) begin
                increment_source_select[i] <= SRC_OFF;
                increment_qualify_mode[i]  <= MODE_RST;
                start_source_select[i]     <= SRC_OFF;
                start_qualify_mode[i]      <= MODE_RST;
                clear_source_select[i]     <= SRC_OFF;
                clear_qualify_mode[i]      <= MODE_RST;
                start_delay_count[i]       <= CNT_RST;
                end_duration_count[i]      <= CNT_RST;
            end
            irq_enable <= '0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                REG_SELECT: if (wb_sel_i[0]) counter_index_select <= wb_dat_i[0];
                REG_INC: if (wb_sel_i[0]) begin
                    increment_source_select[counter_index_select] <= wb_dat_i[SRC_LSB +: SRC_W];
                end
                REG_START: if (wb_sel_i[0]) begin
                    start_source_select[counter_index_select] <= wb_dat_i[SRC_LSB +: SRC_W];
                    if (wb_dat_i[SRC_LSB +: SRC_W] != SRC_OFF) begin
                        clear_source_select[counter_index_select] <= SRC_OFF;
                    end
                end
                REG_CLEAR: if (wb_sel_i[0]) begin
                    clear_source_select[counter_index_select] <= wb_dat_i[SRC_LSB +: SRC_W];
                    if (wb_dat_i[SRC_LSB +: SRC_W] != SRC_OFF) begin
                        start_source_select[counter_index_select] <= SRC_OFF;
                    end
                end
                REG_DELAY: start_delay_count[counter_index_select] <=
                    CW'(lane_merge(32'(start_delay_count[counter_index_select]), wb_dat_i,
                        wb_sel_i));
                REG_DUR: end_duration_count[counter_index_select] <=
                    CW'(lane_merge(32'(end_duration_count[counter_index_select]), wb_dat_i,
                        wb_sel_i));
                REG_IRQ_EN: irq_enable <= IRQ_W'(lane_merge(32'(irq_enable), wb_dat_i, wb_sel_i));
                default: ;
            endcase
            // Mode fields live in byte 1 of their registers
            if (wb_sel_i[1]) begin
                if (wb_adr_i == REG_INC) begin
                    increment_qualify_mode[counter_index_select] <= wb_dat_i[MODE_LSB +: MODE_W];
                end
                if (wb_adr_i == REG_START) begin
                    start_qualify_mode[counter_index_select] <= wb_dat_i[MODE_LSB +: MODE_W];
                end
                if (wb_adr_i == REG_CLEAR) begin
                    clear_qualify_mode[counter_index_select] <= wb_dat_i[MODE_LSB +: MODE_W];
                end
            end
        end
    end

    // Per-counter qualifiers and state machine
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        dect_qualify u_inc (
            .clk     (clk),
            .arst_n  (arst_n),
            .src_vec (src_vec),
            .src_sel (increment_source_select[g]),
            .mode    (increment_qualify_mode[g]),
            .hit     (inc_hit[g])
        );
        dect_qualify u_start (
            .clk     (clk),
            .arst_n  (arst_n),
            .src_vec (src_vec),
            .src_sel (start_source_select[g]),
            .mode    (start_qualify_mode[g]),
            .hit     (start_hit[g])
        );
        dect_qualify u_clear (
            .clk     (clk),
            .arst_n  (arst_n),
            .src_vec (src_vec),
            .src_sel (clear_source_select[g]),
            .mode    (clear_qualify_mode[g]),
            .hit     (clear_hit[g])
        );

        // Count, state, capture and event pulses; clear outranks everything
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                live_count[g]              <= '0;
                count_captured_on_clear[g] <= '0;
                counter_state[g]           <= ST_IDLE;
                delay_done_event[g]        <= 1'b0;
                duration_done_event[g]     <= 1'b0;
                irq_event[g*EV_PER_CNT +: EV_PER_CNT] <= '0;
            end else begin
                delay_done_event[g]    <= 1'b0;
                duration_done_event[g] <= 1'b0;
                irq_event[g*EV_PER_CNT +: EV_PER_CNT] <= '0;
                if (wb_wr && wb_adr_i == REG_CAPT && counter_index_select == 1'(g)) begin
                    count_captured_on_clear[g] <= CW'(wb_dat_i);
                end
                if (clear_hit[g]) begin
                    count_captured_on_clear[g] <= live_count[g];
                    live_count[g]    <= '0;
                    counter_state[g] <= ST_IDLE;
                    irq_event[g*EV_PER_CNT + EV_CLEAR] <= 1'b1;
                end else if (increment_source_select[g] == SRC_OFF) begin
                    counter_state[g] <= ST_IDLE;
                end else begin
                    unique case (counter_state[g])
                        ST_IDLE: counter_state[g] <=
                            (start_source_select[g] == SRC_OFF) ? ST_ACTIVE : ST_WAIT;
                        ST_WAIT: if (start_hit[g]) counter_state[g] <= ST_ACTIVE;
                        ST_ACTIVE: if (inc_hit[g]) begin
                            live_count[g] <= live_count[g] + 1'b1;
                            if (live_count[g] == '1) begin
                                counter_state[g] <= ST_OVF;
                                irq_event[g*EV_PER_CNT + EV_OVF] <= 1'b1;
                            end
                            if (live_count[g] + 1'b1 == start_delay_count[g]) begin
                                delay_done_event[g] <= 1'b1;
                                irq_event[g*EV_PER_CNT + EV_DELAY] <= 1'b1;
                            end
                            if (live_count[g] + 1'b1 == end_duration_count[g]) begin
                                duration_done_event[g] <= 1'b1;
                                counter_state[g] <= ST_DONE;
                                irq_event[g*EV_PER_CNT + EV_DUR] <= 1'b1;
                            end
                        end
                        ST_DONE, ST_OVF: ;
                        default: counter_state[g] <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~((wb_wr && wb_adr_i == REG_IRQ_CLR) ?
                IRQ_W'(wb_dat_i) : IRQ_W'(0))) | irq_event;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rd = 32'h0000_0000;
        unique case (wb_adr_i)
            REG_SELECT: next_rd = 32'(counter_index_select);
            REG_INC: next_rd = 32'({increment_qualify_mode[counter_index_select], 3'h0,
                increment_source_select[counter_index_select]});
            REG_START: next_rd = 32'({start_qualify_mode[counter_index_select], 3'h0,
                start_source_select[counter_index_select]});
            REG_CLEAR: next_rd = 32'({clear_qualify_mode[counter_index_select], 3'h0,
                clear_source_select[counter_index_select]});
            REG_DELAY:  next_rd = 32'(start_delay_count[counter_index_select]);
            REG_DUR:    next_rd = 32'(end_duration_count[counter_index_select]);
            REG_LIVE:   next_rd = 32'(live_count[counter_index_select]);
            REG_CAPT:   next_rd = 32'(count_captured_on_clear[counter_index_select]);
            REG_STATE:  next_rd = 32'(counter_state[counter_index_select]);
            REG_IRQ_ST: next_rd = 32'(irq_status);
            REG_IRQ_EN: next_rd = 32'(irq_enable);
            default:    next_rd = 32'h0000_0000;
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_live_read;
        wb_req && !wb_we_i && wb_adr_i == REG_LIVE;
    endsequence

    chk_tick_period: assert property (microsecond_pulse |-> ##250 microsecond_pulse)
        else $error("tick period wrong");
    chk_tick_single: assert property (microsecond_pulse |=> !microsecond_pulse [*8])
        else $error("tick longer than one cycle");
    chk_src_exclusive: assert property (
        start_source_select[0] == SRC_OFF || clear_source_select[0] == SRC_OFF)
        else $error("start and clear both selected");
    chk_delay_event: assert property (counter_state[0] == ST_ACTIVE && inc_hit[0]
        && !clear_hit[0] && increment_source_select[0] != SRC_OFF
        && live_count[0] + 1'b1 == start_delay_count[0] |=> delay_done_event[0])
        else $error("start event missing at delay");
    chk_end_done: assert property (duration_done_event[0] |-> counter_state[0] == ST_DONE
        && live_count[0] == end_duration_count[0])
        else $error("end event without completion");
    chk_clear_capture: assert property (clear_hit[0] |=> live_count[0] == '0
        && count_captured_on_clear[0] == $past(live_count[0]))
        else $error("clear did not capture and zero");
    chk_wait_start: assert property (counter_state[0] == ST_WAIT && start_hit[0]
        && !clear_hit[0] && increment_source_select[0] != SRC_OFF
        |=> counter_state[0] == ST_ACTIVE)
        else $error("start source ignored");
    chk_live_read: assert property (s_live_read |=> wb_ack_o
        && wb_dat_o == 32'($past(live_count[counter_index_select])))
        else $error("live count read wrong");
    chk_no_count_idle: assert property (counter_state[0] != ST_ACTIVE && !clear_hit[0]
        |=> $stable(live_count[0]))
        else $error("count moved outside active");
endmodule : dect_counter_timer
`default_nettype wire

// >>> include/dect_pkg.sv
// Constants, encodings and carrier types for the dual event counter and timer
package dect_pkg;
    // Widths and sizes
    localparam int CNT_W        = 32;
    localparam int NUM_CNT      = 2;
    localparam int SRC_W        = 5;
    localparam int MODE_W       = 3;
    localparam int NUM_SRC      = 19;
    localparam int ADR_W        = 8;
    localparam int IRQ_W        = 8;
    localparam int EV_PER_CNT   = 4;

    // Source codes, shared by increment, start and clear selections
    localparam logic [SRC_W-1:0] SRC_OFF      = 5'h00;
    localparam logic [SRC_W-1:0] SRC_TICK     = 5'h01;
    localparam logic [SRC_W-1:0] SRC_LINE0    = 5'h02;
    localparam logic [SRC_W-1:0] SRC_USER0    = 5'h06;
    localparam logic [SRC_W-1:0] SRC_C0_START = 5'h0A;
    localparam logic [SRC_W-1:0] SRC_C0_END   = 5'h0C;
    localparam logic [SRC_W-1:0] SRC_LOGIC0   = 5'h0E;
    localparam logic [SRC_W-1:0] SRC_EXP_ST   = 5'h10;
    localparam logic [SRC_W-1:0] SRC_EXP_END  = 5'h11;
    localparam logic [SRC_W-1:0] SRC_FT_WAIT  = 5'h12;

    // Qualify modes
    typedef enum logic [MODE_W-1:0] {
        Q_LEVEL_LOW  = 3'h0,
        Q_LEVEL_HIGH = 3'h1,
        Q_FALL       = 3'h2,
        Q_RISE       = 3'h3,
        Q_ANY        = 3'h4
    } dect_qmode_e;

    // Counter states as read back by software
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_WAIT   = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_DONE   = 3'h3,
        ST_OVF    = 3'h4
    } dect_state_e;

    // Camera-side event sources
    typedef struct packed {
        logic [3:0] line;
        logic [3:0] user_out;
        logic [1:0] logic_blk;
        logic       exp_start;
        logic       exp_end;
        logic       frame_trig_wait;
    } dect_src_s;

    // Register byte offsets
    localparam logic [ADR_W-1:0] REG_SELECT  = 8'h00;
    localparam logic [ADR_W-1:0] REG_INC     = 8'h04;
    localparam logic [ADR_W-1:0] REG_START   = 8'h08;
    localparam logic [ADR_W-1:0] REG_CLEAR   = 8'h0C;
    localparam logic [ADR_W-1:0] REG_DELAY   = 8'h10;
    localparam logic [ADR_W-1:0] REG_DUR     = 8'h14;
    localparam logic [ADR_W-1:0] REG_LIVE    = 8'h18;
    localparam logic [ADR_W-1:0] REG_CAPT    = 8'h1C;
    localparam logic [ADR_W-1:0] REG_STATE   = 8'h20;
    localparam logic [ADR_W-1:0] REG_IRQ_ST  = 8'h24;
    localparam logic [ADR_W-1:0] REG_IRQ_CLR = 8'h28;
    localparam logic [ADR_W-1:0] REG_IRQ_EN  = 8'h2C;

    // Field positions in source/mode registers
    localparam int SRC_LSB  = 0;
    localparam int MODE_LSB = 8;

    // Interrupt bit positions within one counter's group
    localparam int EV_DELAY = 0;
    localparam int EV_DUR   = 1;
    localparam int EV_CLEAR = 2;
    localparam int EV_OVF   = 3;

    // Reset values
    localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h3;

    // Microsecond tick timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage : dect_pkg

// >>> hw/dect_qualify.sv
// Source select and level/edge qualification for one counter input
`timescale 1ns/1ns
`default_nettype none
module dect_qualify
    import dect_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // Selection
    input  wire logic [NUM_SRC-1:0]    src_vec,
    input  wire logic [SRC_W-1:0]      src_sel,
    input  wire logic [MODE_W-1:0]     mode,
    // Qualified event
    output logic                       hit
);
    logic sig;
    logic prev;

    // Codes past the list and the off code select a constant low
    assign sig = (src_sel < SRC_W'(NUM_SRC)) ? src_vec[src_sel] : 1'b0;

    // Previous level; a source change may show one false edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= sig;
        end
    end

    // Mode decode
    always_comb begin
        hit = 1'b0;
        if (src_sel != SRC_OFF) begin
            unique case (mode)
                Q_LEVEL_LOW:  hit = !sig;
                Q_LEVEL_HIGH: hit = sig;
                Q_FALL:       hit = prev && !sig;
                Q_RISE:       hit = !prev && sig;
                Q_ANY:        hit = prev != sig;
                default:      hit = 1'b0;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_rise_qual: assert property (hit && mode == Q_RISE |-> sig && !$past(sig))
        else $error("rising edge hit without a rising edge");
endmodule : dect_qualify
`default_nettype wire

// >>> verification/dect_src_model.sv
// Camera-side source model: lines, user outputs and exposure signals
`timescale 1ns/1ns
`default_nettype none
module dect_src_model
    import dect_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               arst_n,
    // Requested levels and what the device sees
    input  wire dect_pkg::dect_src_s lvl,
    output var  dect_pkg::dect_src_s src
);
    // Registered like a synchronised pin, so edges land on clean cycle boundaries
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src <= '0;
        end else begin
            src <= lvl;
        end
    end
endmodule : dect_src_model
`default_nettype wire

// >>> verification/test_dect_counter_timer.sv
// Self-checking bench for the dual event counter and timer
`timescale 1ns/1ns
`default_nettype none
module test_dect_counter_timer;
    import dect_pkg::*;
    logic        clk = 1'b0, arst_n, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic        ack, us, irq;
    logic [1:0]  dly_ev, dur_ev;
    dect_src_s   lvl = '0, src;
    int          mismatches = 0, tests_run = 0, cycles = 0, dly_n = 0, dur_n = 0, idle_n = 0, n;

    always #2 clk = ~clk;

    dect_src_model u_dect_src_model (.clk(clk), .arst_n(arst_n), .lvl(lvl), .src(src));
    dect_counter_timer u_dect_counter_timer (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .src_i(src), .delay_done_event(dly_ev), .duration_done_event(dur_ev),
        .microsecond_pulse(us), .irq(irq));

    // Event pulses counted here, since they stand for one cycle only; also the hang guard
    always @(posedge clk) begin
        cycles++;
        if (dly_ev[0] === 1'b1) dly_n++;
        if (dur_ev[0] === 1'b1) dur_n++;
        // Counter 1 is never armed, so any event or unknown from it is wrong
        if (dly_ev[1] !== 1'b0 || dur_ev[1] !== 1'b0) idle_n++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    // One classic cycle; held until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
        chk({31'h0, ack}, 32'h0, "ack longer than one cycle");
    endtask : wb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
        wb(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask : rd_chk

    // Full high pulse on one line; the falling half must not count in rise mode
    task automatic pulse(input int b);
        lvl.line[b] <= 1'b1;
        repeat (4) @(posedge clk);
        lvl.line[b] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic t_reset;
        rd_chk(REG_SELECT, 32'h0, "select reset");
        rd_chk(REG_INC, 32'h300, "increment reset");
        rd_chk(REG_STATE, 32'h0, "state reset");
        rd_chk(REG_LIVE, 32'h0, "live count reset");
        rd_chk(8'h80, 32'h0, "unmapped read");
        chk({31'h0, irq}, 32'h0, "irq after reset");
    endtask : t_reset

    task automatic t_count;
        wb(1'b1, REG_DELAY, 32'h1);
        wb(1'b1, REG_DUR, 32'h2);
        wb(1'b1, REG_INC, {21'h0, Q_RISE, 3'h0, SRC_LINE0});
        rd_chk(REG_STATE, ST_ACTIVE, "active with start off");
        pulse(0);
        chk(dly_n, 1, "delay event");
        rd_chk(REG_LIVE, 32'h1, "one rising edge");
        pulse(0);
        chk(dur_n, 1, "duration event");
        chk(dly_n, 1, "delay event once");
        rd_chk(REG_LIVE, 32'h2, "two rising edges");
        rd_chk(REG_STATE, ST_DONE, "completed");
        rd_chk(REG_IRQ_ST, 32'h3, "delay and duration status");
        wb(1'b1, REG_SELECT, 32'h1);
        rd_chk(REG_INC, 32'h300, "second counter untouched");
        rd_chk(REG_LIVE, 32'h0, "second counter count");
        wb(1'b1, REG_SELECT, 32'h0);
    endtask : t_count

    task automatic t_irq;
        wb(1'b1, REG_IRQ_EN, 32'h2);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        wb(1'b1, REG_IRQ_EN, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wb(1'b1, REG_IRQ_EN, 32'h2);
        wb(1'b1, REG_IRQ_CLR, 32'h2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(REG_IRQ_ST, 32'h1, "other status kept");
    endtask : t_irq

    task automatic t_clear;
        wb(1'b1, REG_START, {21'h0, Q_RISE, 3'h0, 5'h04});
        wb(1'b1, REG_CLEAR, {21'h0, Q_RISE, 3'h0, 5'h03});
        wb(1'b0, REG_START, 32'h0);
        chk(q & 32'h1F, 32'h0, "start source dropped");
        rd_chk(REG_CLEAR, 32'h303, "clear source kept");
        pulse(1);
        rd_chk(REG_CAPT, 32'h2, "captured on clear");
        rd_chk(REG_LIVE, 32'h0, "count cleared");
        wb(1'b0, REG_IRQ_ST, 32'h0);
        chk(q & 32'h4, 32'h4, "clear status");
    endtask : t_clear

    task automatic t_tick;
        n = 0;
        while (us !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (us !== 1'b1 && n < 600);
        chk(n, TICK_CYCLES, "tick period");
    endtask : t_tick

    // Returns at the edge where a tick pulse is seen
    task automatic wait_tick;
        n = 0;
        while (us !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_tick

    // Start on a falling edge, count any edge, then clear once on the tick
    task automatic t_start;
        wb(1'b1, REG_IRQ_CLR, 32'hFF);
        wb(1'b1, REG_INC, 32'h0);
        wb(1'b1, REG_DELAY, 32'h2);
        wb(1'b1, REG_DUR, 32'h3);
        wb(1'b1, REG_START, {21'h0, Q_FALL, 3'h0, 5'h04});
        wb(1'b1, REG_INC, {21'h0, Q_ANY, 3'h0, SRC_USER0});
        rd_chk(REG_STATE, ST_WAIT, "waiting for start");
        lvl.user_out[0] <= 1'b1;
        lvl.line[2] <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(REG_LIVE, 32'h0, "no count before start");
        rd_chk(REG_STATE, ST_WAIT, "rise ignored in fall mode");
        lvl.line[2] <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(REG_STATE, ST_ACTIVE, "started on fall");
        repeat (3) begin
            lvl.user_out[0] <= ~lvl.user_out[0];
            repeat (4) @(posedge clk);
        end
        chk(dly_n, 2, "delay event on any edge");
        chk(dur_n, 2, "duration event on any edge");
        rd_chk(REG_LIVE, 32'h3, "any edge counted");
        rd_chk(REG_STATE, ST_DONE, "completed again");
        rd_chk(REG_IRQ_ST, 32'h3, "status after software clear");
        // Sync to a tick first so exactly one clear lands before the read
        wait_tick();
        wb(1'b1, REG_CLEAR, {21'h0, Q_LEVEL_HIGH, 3'h0, SRC_TICK});
        rd_chk(REG_START, 32'h200, "start dropped by clear");
        wait_tick();
        rd_chk(REG_CAPT, 32'h3, "captured on tick clear");
        rd_chk(REG_LIVE, 32'h0, "tick clear zeroed count");
        chk(idle_n, 0, "idle counter silent");
    endtask : t_start

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        // Unknown to low gives the flops a real reset edge
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_count();
        t_irq();
        t_clear();
        t_start();
        t_tick();
        results();
    end
endmodule : test_dect_counter_timer
`default_nettype wire
